//--- logic/scc_top.v
// split completion controller: the completer end that returns read data
// and single-dword completion messages to a requester on a registered bus.
// assumes apb software loads the sequence, then feeds data words one by one;
// the requester drives its target controls from flops on the same clock.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "scc_map.vh"

module scc_top (
    input wire clk_in,
    input wire sys_rst_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    input wire devsel_n_in,
    input wire trdy_n_in,
    input wire stop_n_in,
    output reg frame_n_out,
    output reg frame_oe_out,
    output reg irdy_n_out,
    output reg irdy_oe_out,
    output reg [31:0] ad_out,
    output reg ad_oe_out,
    output reg [3:0] cbe_out,
    output reg cbe_oe_out
);

    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam S_IDLE = 3'd0;
    localparam S_ADDR = 3'd1;
    localparam S_ATTR = 3'd2;
    localparam S_RESP = 3'd3;
    localparam S_DATA = 3'd4;
    localparam S_GAP = 3'd5;
    localparam S_END = 3'd6;

    reg [2:0] state;
    reg [2:0] next_state;
    reg [7:0] wcnt;
    reg [7:0] next_wcnt;
    reg [3:0] tmr;
    reg [3:0] next_tmr;
    reg in_msg;
    reg next_in_msg;
    reg halt;
    reg next_halt;
    reg take;
    reg [4:0] ev;
    reg next_final;

    // configuration and data holding
    reg msg_en;
    reg burst;
    reg [20:0] seq_id;
    reg [6:0] start_la;
    reg [11:0] req_bc;
    reg [7:0] ndw;
    reg [3:0] msg_class;
    reg [7:0] msg_index;
    reg [15:0] cid;
    reg [31:0] data_word;
    reg data_full;
    reg [4:0] sticky;

    // synchronisers for the target controls
    reg devsel_m;
    reg devsel_s;
    reg trdy_m;
    reg trdy_s;
    reg stop_m;
    reg stop_s;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // 12-bit count with zero meaning 4096, widened to 13 bits
    function [12:0] full_count;
        input [11:0] bc;
        begin
            full_count = {(bc == 12'h000), bc};
        end
    endfunction

    // bytes moved by the data transaction
    function [12:0] sent_bytes;
        input [7:0] n;
        begin
            sent_bytes = {3'b000, n, 2'b00};
        end
    endfunction

    wire idle = (state == S_IDLE);
    wire acc = psel_in & penable_in;
    wire wr = acc & pready_out & pwrite_in;
    wire wr_ctrl = wr & (paddr_in == `SCC_REG_CTRL);
    wire wr_data = wr & (paddr_in == `SCC_REG_DATA);
    wire wr_cfg = wr & idle;
    wire start = wr_ctrl & pwdata_in[`SCC_CTRL_START] & idle;
    wire clr = wr_ctrl & pwdata_in[`SCC_CTRL_CLR];
    wire class_ok = (msg_class == `SCC_CLS_WRITE) |
        (msg_class == `SCC_CLS_BRIDGE) | (msg_class == `SCC_CLS_COMPL);
    wire err_cls = (msg_class == `SCC_CLS_BRIDGE) |
        (msg_class == `SCC_CLS_COMPL);
    wire mapped = (paddr_in[1:0] == 2'b00) & (paddr_in <= `SCC_REG_CID);
    wire [12:0] rem_full = full_count(req_bc) - sent_bytes(ndw);

    // remaining address and count; dword requests and write class get 0/4
    wire plain_rem = ~burst | (msg_class == `SCC_CLS_WRITE);
    wire [6:0] rem_la = plain_rem ? 7'h00 :
        (start_la + {ndw[4:0], 2'b00});
    wire [11:0] rem_bc = plain_rem ? `SCC_MSG_BYTES :
        rem_full[11:0];

    // message word, reserved bit always zero
    wire [31:0] msg_word = {msg_class, msg_index, 1'b0,
        rem_la, rem_bc};

    // attribute byte count: message four, disconnecting data short
    wire [11:0] attr_bc = in_msg ? `SCC_MSG_BYTES :
        (msg_en ? {2'b00, ndw, 2'b00} :
        req_bc);
    wire [31:0] attr_word = {1'b0, in_msg & err_cls, in_msg,
        ~in_msg & msg_en, 4'h0, cid, attr_bc[7:0]};
    wire [6:0] addr_la = (next_in_msg | ~burst) ? 7'h00 : start_la;
    wire [31:0] addr_word = {3'b000, seq_id[20:16], seq_id[15:0],
        1'b0, addr_la};
    wire limit_hit = (tmr == (`SCC_DEVSEL_CLKS + `SCC_SYNC_CLKS));

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            devsel_m <= 1'b1;
            devsel_s <= 1'b1;
            trdy_m <= 1'b1;
            trdy_s <= 1'b1;
            stop_m <= 1'b1;
            stop_s <= 1'b1;
        end
        else
        begin
            devsel_m <= devsel_n_in;
            devsel_s <= devsel_m;
            trdy_m <= trdy_n_in;
            trdy_s <= trdy_m;
            stop_m <= stop_n_in;
            stop_s <= stop_m;
        end
    end

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    // a data write waits while the holding word is still unsent
    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
        end
        else
        begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            if (acc && !pready_out &&
                !(pwrite_in && paddr_in == `SCC_REG_DATA && data_full))
            begin
                pready_out <= 1'b1;
                pslverr_out <= ~mapped;
                case (paddr_in)
                    `SCC_REG_CTRL: prdata_out <= {29'h0000_0000, burst,
                        msg_en, 1'b0};
                    `SCC_REG_SEQ: prdata_out <= {11'h000, seq_id};
                    `SCC_REG_REQ: prdata_out <= {4'h0, ndw, req_bc,
                        1'b0, start_la};
                    `SCC_REG_MSG: prdata_out <= {20'h0_0000, msg_index,
                        msg_class};
                    `SCC_REG_STAT: prdata_out <= {16'h0000, wcnt, 1'b0,
                        data_full, sticky, ~idle};
                    `SCC_REG_CID: prdata_out <= {16'h0000, cid};
                    default: prdata_out <= 32'h0000_0000;
                endcase
            end
        end
    end

    // configuration writes only land while no sequence runs
    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            msg_en <= 1'b0;
            burst <= 1'b0;
            seq_id <= 21'h00_0000;
            start_la <= 7'h00;
            req_bc <= 12'h004;
            ndw <= 8'h00;
            msg_class <= 4'h0;
            msg_index <= 8'h00;
            cid <= 16'h0000;
        end
        else if (wr_cfg)
        begin
            case (paddr_in)
                `SCC_REG_CTRL:
                begin
                    msg_en <= pwdata_in[`SCC_CTRL_MSG];
                    burst <= pwdata_in[`SCC_CTRL_BURST];
                end
                `SCC_REG_SEQ: seq_id <= pwdata_in[20:0];
                `SCC_REG_REQ:
                begin
                    start_la <= pwdata_in[6:0];
                    req_bc <= pwdata_in[19:8];
                    ndw <= pwdata_in[27:20];
                end
                `SCC_REG_MSG:
                begin
                    msg_class <= pwdata_in[3:0];
                    msg_index <= pwdata_in[11:4];
                end
                `SCC_REG_CID: cid <= pwdata_in[15:0];
                default: cid <= cid;
            endcase
        end
    end

    // one-word holding register; take and write never coincide
    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            data_word <= 32'h0000_0000;
        else if (wr_data)
            data_word <= pwdata_in;
    end

    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            data_full <= 1'b0;
        else if (take)
            data_full <= 1'b0;
        else if (wr_data)
            data_full <= 1'b1;
    end

    // sticky status: a new event wins over a clear in the same cycle
    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            sticky <= 5'h00;
        else
            sticky <= (clr ? 5'h00 : sticky) | ev;
    end

    // ------------------------------------------------------------
    // sequence engine
    // ------------------------------------------------------------
    always @*
    begin
        next_state = state;
        next_wcnt = wcnt;
        next_tmr = tmr;
        next_in_msg = in_msg;
        next_halt = halt;
        take = 1'b0;
        ev = 5'h00;
        case (state)
            S_IDLE:
                if (start)
                begin
                    next_wcnt = 8'h00;
                    next_halt = 1'b0;
                    next_in_msg = (ndw == 8'h00);
                    if (msg_en && !class_ok)
                        ev[`SCC_ST_BADCLS - 1] = 1'b1;
                    else if (ndw == 8'h00 && !msg_en)
                        ev[`SCC_ST_DONE - 1] = 1'b1;
                    else
                        next_state = S_ADDR;
                end
            S_ADDR: next_state = S_ATTR;
            S_ATTR:
            begin
                next_state = S_RESP;
                next_tmr = 4'h0;
            end
            S_RESP:
                if (!devsel_s && stop_s && trdy_s)
                    next_state = S_DATA;
                else if (!stop_s && devsel_s)
                begin
                    ev[`SCC_ST_TABORT - 1] = 1'b1;
                    next_halt = 1'b1;
                    next_state = S_END;
                end
                else if (!devsel_s || !stop_s || !trdy_s)
                begin
                    ev[`SCC_ST_BADTERM - 1] = 1'b1;
                    next_halt = 1'b1;
                    next_state = S_END;
                end
                else if (limit_hit)
                begin
                    ev[`SCC_ST_MABORT - 1] = 1'b1;
                    next_halt = 1'b1;
                    next_state = S_END;
                end
                else
                    next_tmr = tmr + 4'h1;
            S_DATA:
                if (!stop_s)
                begin
                    if (devsel_s)
                        ev[`SCC_ST_TABORT - 1] = 1'b1;
                    else
                        ev[`SCC_ST_BADTERM - 1] = 1'b1;
                    next_halt = 1'b1;
                    next_state = S_END;
                end
                else if (!irdy_n_out && !trdy_s && !devsel_s)
                begin
                    take = ~in_msg;
                    next_wcnt = in_msg ? wcnt : wcnt + 8'h01;
                    next_state = S_GAP;
                end
            S_GAP:
                if (trdy_s)
                    next_state = (in_msg || wcnt == ndw) ? S_END : S_DATA;
            S_END:
                if (!halt && !in_msg && msg_en)
                begin
                    next_in_msg = 1'b1;
                    next_state = S_ADDR;
                end
                else
                begin
                    ev[`SCC_ST_DONE - 1] = ~halt;
                    next_state = S_IDLE;
                end
            default: next_state = S_IDLE;
        endcase
        next_final = next_in_msg | ((next_wcnt + 8'h01) == ndw) |
            (next_state == S_GAP && (next_in_msg || next_wcnt == ndw));
    end

    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            state <= S_IDLE;
            wcnt <= 8'h00;
            tmr <= 4'h0;
            in_msg <= 1'b0;
            halt <= 1'b0;
        end
        else
        begin
            state <= next_state;
            wcnt <= next_wcnt;
            tmr <= next_tmr;
            in_msg <= next_in_msg;
            halt <= next_halt;
        end
    end

    // ------------------------------------------------------------
    // registered pin drive
    // ------------------------------------------------------------
    // frame drops on the last data phase; byte enables stay high
    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            frame_n_out <= 1'b1;
            frame_oe_out <= 1'b0;
            irdy_n_out <= 1'b1;
            irdy_oe_out <= 1'b0;
            ad_out <= 32'h0000_0000;
            ad_oe_out <= 1'b0;
            cbe_out <= `SCC_CBE_IDLE;
            cbe_oe_out <= 1'b0;
        end
        else
        begin
            frame_n_out <= ~((next_state == S_ADDR) ||
                (next_state == S_ATTR) || (next_state == S_RESP) ||
                ((next_state == S_DATA || next_state == S_GAP) &&
                !next_final));
            frame_oe_out <= (next_state != S_IDLE);
            irdy_n_out <= ~((next_state == S_DATA) &&
                (next_in_msg || (data_full && !take)));
            irdy_oe_out <= (next_state != S_IDLE) && (next_state != S_ADDR);
            ad_oe_out <= (next_state == S_ADDR) || (next_state == S_ATTR) ||
                (next_state == S_DATA) || (next_state == S_GAP);
            cbe_oe_out <= (next_state == S_ADDR) || (next_state == S_ATTR) ||
                (next_state == S_DATA) || (next_state == S_GAP);
            case (next_state)
                S_ADDR:
                begin
                    ad_out <= addr_word;
                    cbe_out <= `SCC_CMD_SPLIT;
                end
                S_ATTR:
                begin
                    ad_out <= attr_word;
                    cbe_out <= attr_bc[11:8];
                end
                S_DATA:
                begin
                    ad_out <= next_in_msg ? msg_word : data_word;
                    cbe_out <= `SCC_CBE_IDLE;
                end
                default:
                begin
                    ad_out <= ad_out;
                    cbe_out <= `SCC_CBE_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

//--- common/scc_map.vh
// constants for the split completion controller: register map, field
// positions, bus encodings and timing counts.
// assumes one 100 MHz clock shared by the apb side and the bus pins.
`ifndef SCC_MAP_VH
`define SCC_MAP_VH

// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define SCC_REG_CTRL 8'h00
`define SCC_REG_SEQ 8'h04
`define SCC_REG_REQ 8'h08
`define SCC_REG_MSG 8'h0C
`define SCC_REG_DATA 8'h10
`define SCC_REG_STAT 8'h14
`define SCC_REG_CID 8'h18

// ------------------------------------------------------------
// control and status bit positions
// ------------------------------------------------------------
`define SCC_CTRL_START 0
`define SCC_CTRL_MSG 1
`define SCC_CTRL_BURST 2
`define SCC_CTRL_CLR 3
`define SCC_ST_BUSY 0
`define SCC_ST_DONE 1
`define SCC_ST_TABORT 2
`define SCC_ST_MABORT 3
`define SCC_ST_BADTERM 4
`define SCC_ST_BADCLS 5
`define SCC_ST_FULL 6

// ------------------------------------------------------------
// message classes and indices
// ------------------------------------------------------------
`define SCC_CLS_WRITE 4'h0
`define SCC_CLS_BRIDGE 4'h1
`define SCC_CLS_COMPL 4'h2
`define SCC_IDX_NORMAL 8'h00
`define SCC_MSG_BYTES 12'h004

// ------------------------------------------------------------
// bus encodings and timing counts
// ------------------------------------------------------------
`define SCC_CMD_SPLIT 4'hC
`define SCC_CBE_IDLE 4'hF
`define SCC_DEVSEL_CLKS 4'h6
`define SCC_SYNC_CLKS 4'h2

`endif

//--- test/scc_monitor.sv
// checker for the bus side of the split completion controller.
// assumes a bind to scc_top; it sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// message and data phase framing checks
// ----------------------------------------
module scc_monitor (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic frame_n_out,
    input wire logic irdy_n_out,
    input wire logic [31:0] ad_out,
    input wire logic [3:0] cbe_out
);
    logic hdr_d;
    logic msg_f;
    logic err_f;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    // keep the attribute flags for the data phase
    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            hdr_d <= 1'b0;
            msg_f <= 1'b0;
            err_f <= 1'b0;
        end
        else
        begin
            hdr_d <= $fell(frame_n_out);
            if (hdr_d)
            begin
                msg_f <= ad_out[29];
                err_f <= ad_out[30];
            end
        end
    end
    // address phase, then attribute phase flagging a message
    sequence s_msg_hdr;
        $fell(frame_n_out) ##1 ad_out[29];
    endsequence
    sequence s_msg_data;
        !irdy_n_out && msg_f;
    endsequence
    chk_msg_addr_zero: assert property (s_msg_hdr |-> $past(ad_out[6:0]) == 7'h00)
        else $error("message address not zero");
    chk_msg_count_four: assert property (s_msg_hdr |-> ad_out[7:0] == 8'h04 && cbe_out == 4'h0)
        else $error("message byte count not four");
    chk_msg_one_phase: assert property (s_msg_data |-> frame_n_out)
        else $error("message longer than one dword");
    chk_data_cbe_high: assert property (!irdy_n_out |-> cbe_out == 4'hF)
        else $error("byte enables low in data phase");
    chk_rsv_bit_zero: assert property (s_msg_data |-> !ad_out[19])
        else $error("reserved message bit set");
    chk_class_legal: assert property (s_msg_data |-> ad_out[31:28] <= 4'h2)
        else $error("reserved message class sent");
    chk_err_flag: assert property (s_msg_data |-> err_f == (ad_out[31:28] != 4'h0))
        else $error("error flag disagrees with class");
    chk_write_done: assert property ((!irdy_n_out && msg_f && ad_out[31:28] == 4'h0)
        |-> ad_out[18:0] == 19'h0_0004)
        else $error("write completion remainder wrong");
endmodule
bind scc_top scc_monitor chk_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .frame_n_out(frame_n_out), .irdy_n_out(irdy_n_out), .ad_out(ad_out),
    .cbe_out(cbe_out));
`default_nettype wire

//--- test/scc_requester.sv
// requester model: claims, paces and decodes split completions.
// assumes registered outputs of scc_top; released controls read high.
`timescale 1ns/1ps
`default_nettype none
module scc_requester (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic frame_n_in,
    input wire logic irdy_n_in,
    input wire logic [31:0] ad_in,
    input wire logic [3:0] cbe_in,
    input wire logic [20:0] seq_in,
    input wire logic abort_in,
    input wire logic [3:0] slow_in,
    output logic devsel_n_out,
    output logic trdy_n_out,
    output logic stop_n_out,
    output logic [31:0] msg_out,
    output logic [35:0] dattr_out,
    output logic [35:0] mattr_out,
    output logic [31:0] dfirst_out,
    output logic [7:0] dcnt_out,
    output logic [7:0] nmsg_out,
    output logic oor_out,
    output logic [3:0] code_out
);
    logic [1:0] st;
    logic fprev;
    logic hit;
    logic ismsg, lastw;
    logic [3:0] wt;
    logic [7:0] cnt;
    // one pass per transaction; a slow setting delays the first trdy of each transaction
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st <= 2'd0;
            fprev <= 1'b1;
            devsel_n_out <= 1'b1;
            trdy_n_out <= 1'b1;
            stop_n_out <= 1'b1;
            nmsg_out <= 8'h00;
            oor_out <= 1'b0;
            code_out <= 4'h0;
        end
        else
        begin
            fprev <= frame_n_in;
            if (st == 2'd0 && fprev && !frame_n_in)
            begin
                hit <= (ad_in[28:8] == seq_in);
                st <= 2'd1;
            end
            else if (st == 2'd1)
            begin
                ismsg <= ad_in[29];
                if (ad_in[29])
                    mattr_out <= {cbe_in, ad_in};
                else
                    dattr_out <= {cbe_in, ad_in};
                devsel_n_out <= !hit || abort_in;
                stop_n_out <= !(hit && abort_in);
                cnt <= 8'h00;
                wt <= 4'h0;
                st <= hit ? 2'd2 : 2'd0;
            end
            else if (st == 2'd2)
            begin
                // no buffer limit: any count is taken whole
                if (!irdy_n_in && trdy_n_out)
                begin
                    wt <= wt + 4'h1;
                    if (wt >= slow_in)
                    begin
                        trdy_n_out <= 1'b0;
                        lastw <= frame_n_in;
                        cnt <= cnt + 8'h01;
                        if (ismsg)
                            msg_out <= ad_in;
                        else if (cnt == 8'h00)
                            dfirst_out <= ad_in;
                    end
                end
                if (irdy_n_in && !trdy_n_out)
                    trdy_n_out <= 1'b1;
                if (irdy_n_in && frame_n_in && trdy_n_out && (lastw && cnt != 0 || abort_in))
                begin
                    devsel_n_out <= 1'b1;
                    stop_n_out <= 1'b1;
                    st <= 2'd0;
                    if (!ismsg)
                        dcnt_out <= cnt;
                    else if (cnt != 8'h00)
                    begin
                        nmsg_out <= nmsg_out + 8'h01;
                        // bit 19 is never looked at
                        if (msg_out[31:20] == 12'h200)
                            oor_out <= 1'b1;
                        if (msg_out[31:24] == 8'h28)
                            code_out <= msg_out[23:20];
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- test/tb_scc_top.sv
// testbench for scc_top with the requester model on the bus side.
// assumes scc_map.vh on the include path; apb driven at rising edges.
`timescale 1ns/1ps
`default_nettype none
`include "scc_map.vh"
module tb_scc_top;
    typedef struct packed {
        logic b;
        logic m;
        logic [3:0] s;
        logic [7:0] n;
        logic [11:0] bc;
        logic [6:0] la;
        logic [3:0] c;
        logic [7:0] x;
        logic [31:0] mw;
        logic [11:0] ac;
    } scc_row_t;
    localparam logic [20:0] SEQ_ID = 21'h1_A53C;
    scc_row_t rows [0:5];
    scc_row_t r;
    logic clk_in, sys_rst_in, psel_in, penable_in, pwrite_in;
    logic [7:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, ad_out, msg, dfirst, rd_q;
    logic pready_out, pslverr_out, devsel_n, trdy_n, stop_n, oor, abort_q;
    logic frame_n_out, frame_oe_out, irdy_n_out, irdy_oe_out, ad_oe_out;
    logic [3:0] cbe_out, code, slow_q;
    logic cbe_oe_out, err_q;
    logic [35:0] dattr, mattr;
    logic [7:0] dcnt, nmsg, nm;
    logic [20:0] seq_q;
    integer num_errors, n_tests, i;
    scc_top dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .devsel_n_in(devsel_n), .trdy_n_in(trdy_n), .stop_n_in(stop_n),
        .frame_n_out(frame_n_out), .frame_oe_out(frame_oe_out),
        .irdy_n_out(irdy_n_out), .irdy_oe_out(irdy_oe_out), .ad_out(ad_out),
        .ad_oe_out(ad_oe_out), .cbe_out(cbe_out), .cbe_oe_out(cbe_oe_out));
    scc_requester rq_u (.clk_in(clk_in), .rst_in(sys_rst_in),
        .frame_n_in(frame_n_out), .irdy_n_in(irdy_n_out), .ad_in(ad_out),
        .cbe_in(cbe_out), .seq_in(seq_q), .abort_in(abort_q),
        .slow_in(slow_q), .devsel_n_out(devsel_n), .trdy_n_out(trdy_n),
        .stop_n_out(stop_n), .msg_out(msg), .dattr_out(dattr),
        .mattr_out(mattr), .dfirst_out(dfirst), .dcnt_out(dcnt),
        .nmsg_out(nmsg), .oor_out(oor), .code_out(code));
    // free running clock
    always #5 clk_in = ~clk_in;
    task end_sim;
        begin
            if (num_errors == 0 && n_tests > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task chk(input logic [35:0] got, input logic [35:0] exp);
        begin
            n_tests++;
            if (got !== exp)
            begin
                num_errors++;
                $display("wrong value at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    // one apb transfer, held until pready sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        integer k;
        begin
            psel_in <= 1'b1;
            pwrite_in <= w;
            paddr_in <= a;
            pwdata_in <= d;
            @(posedge clk_in);
            penable_in <= 1'b1;
            k = 0;
            do
            begin
                @(posedge clk_in);
                k++;
            end
            while (pready_out !== 1'b1 && k < 300);
            rd_q = prdata_out;
            err_q = pslverr_out;
            if (k >= 300)
            begin
                num_errors++;
                end_sim;
            end
            psel_in <= 1'b0;
            penable_in <= 1'b0;
            @(posedge clk_in);
        end
    endtask
    // load a sequence, feed words, poll until it settles
    task run(input scc_row_t q);
        integer k;
        begin
            apb(1'b1, `SCC_REG_SEQ, {11'h000, SEQ_ID});
            apb(1'b1, `SCC_REG_REQ, {4'h0, q.n, q.bc, 1'b0, q.la});
            apb(1'b1, `SCC_REG_MSG, {20'h0_0000, q.x, q.c});
            apb(1'b1, `SCC_REG_CTRL, {29'h0000_0001, q.b, q.m, 1'b0});
            if (q.n != 8'h00)
                apb(1'b1, `SCC_REG_DATA, 32'hA000_0000);
            apb(1'b1, `SCC_REG_CTRL, {29'h0000_0000, q.b, q.m, 1'b1});
            for (k = 1; k < q.n; k++)
                apb(1'b1, `SCC_REG_DATA, 32'hA000_0000 + k);
            k = 0;
            do
            begin
                apb(1'b0, `SCC_REG_STAT, 32'h0000_0000);
                k++;
            end
            while (rd_q[5:1] === 5'h00 && k < 100);
        end
    endtask
    initial
    begin
        clk_in = 0;
        sys_rst_in = 1;
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = 0;
        {num_errors, n_tests} = 0;
        seq_q = SEQ_ID;
        abort_q = 0;
        slow_q = 0;
        rows[0] = '{0, 1, 0, 0, 12'h004, 7'h00, 0, 8'h00, 32'h0000_0004, 0};
        rows[1] = '{1, 1, 3, 2, 12'h040, 7'h10, 2, 8'h00, 32'h2001_8038, 8};
        rows[2] = '{0, 1, 0, 0, 12'h004, 7'h00, 2, 8'h01, 32'h2010_0004, 0};
        rows[3] = '{1, 1, 1, 0, 12'h100, 7'h7C, 2, 8'h85, 32'h2857_C100, 0};
        rows[4] = '{1, 1, 0, 1, 12'h010, 7'h7C, 1, 8'h00, 32'h1000_000C, 4};
        rows[5] = '{1, 0, 2, 3, 12'h00C, 7'h00, 0, 8'h00, 32'h0000_0000, 12};
        repeat (20) @(posedge clk_in);
        chk(36'({frame_n_out, irdy_n_out, cbe_out, frame_oe_out, irdy_oe_out,
            ad_oe_out, cbe_oe_out}), 36'h0_0000_03F0);
        sys_rst_in <= 1'b0;
        // table of ordinary sequences
        for (i = 0; i < 6; i++)
        begin
            r = rows[i];
            slow_q <= r.s;
            run(r);
            chk(36'(rd_q[1]), 36'h0_0000_0001);
            if (r.m)
            begin
                chk(36'(msg), 36'(r.mw));
                chk(36'(mattr[30]), 36'(r.c != 4'h0));
            end
            if (r.n != 8'h00)
            begin
                chk(36'(dcnt), 36'(r.n));
                chk(36'(dfirst), 36'h0_A000_0000);
                chk(36'({dattr[35:32], dattr[7:0]}), 36'(r.ac));
            end
        end
        chk(36'({oor, code}), 36'h0_0000_0015);
        // unmapped address
        apb(1'b0, 8'h1C, 32'h0000_0000);
        chk(36'({err_q, rd_q}), 36'h1_0000_0000);
        // reserved class is refused without a message
        nm = nmsg;
        r = rows[0];
        r.c = 4'h3;
        run(r);
        chk(36'({rd_q[5], nmsg}), 36'({1'b1, nm}));
        // nobody claims: master abort
        seq_q <= 21'h0_0001;
        run(rows[2]);
        chk(36'({rd_q[3], nmsg}), 36'({1'b1, nm}));
        // target abort halts the sequence
        seq_q <= SEQ_ID;
        abort_q <= 1'b1;
        run(rows[2]);
        chk(36'({rd_q[2], nmsg}), 36'({1'b1, nm}));
        end_sim;
    end
endmodule
`default_nettype wire
